/* include/sli_pkg.sv */
package sli_pkg;

  // ==========================================================
  // clock and blink timing
  // ==========================================================
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned BLINK_SLOW_HZ = 1;
  localparam int unsigned BLINK_FAST_HZ = 2;
  // half period in cycles: equal on and off phases
  localparam int unsigned SLOW_HALF_CYC = CLK_HZ / (2 * BLINK_SLOW_HZ);
  localparam int unsigned FAST_HALF_CYC = CLK_HZ / (2 * BLINK_FAST_HZ);

  // ==========================================================
  // firmware gate for the newer function package (V2.00.0)
  // ==========================================================
  localparam logic [7:0] FW_PKG2_MAJOR = 8'h02;
  localparam logic [7:0] FW_PKG2_MINOR = 8'h00;
  localparam logic [7:0] FW_PKG2_PATCH = 8'h00;
  localparam logic [23:0] FW_PKG2_MIN = {FW_PKG2_MAJOR, FW_PKG2_MINOR,
    FW_PKG2_PATCH};

  // ==========================================================
  // register map (byte addresses)
  // ==========================================================
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_FWVER = 8'h08;
  localparam logic [7:0] ADDR_UPLOAD = 8'h0C;
  // control bit positions
  localparam int unsigned CTRL_IDENT_BIT = 0;
  localparam int unsigned CTRL_VERIFIED_BIT = 1;
  localparam int unsigned CTRL_ERRCLR_BIT = 2;
  // upload register: bit0 = upload strobe, bit1 = newer package
  localparam int unsigned UPL_GO_BIT = 0;
  localparam int unsigned UPL_PKG2_BIT = 1;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [23:0] FWVER_RST = 24'h020000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // system state from the controller core
  // ==========================================================
  typedef enum logic [2:0] {
    SLI_SYS_OFF = 3'h0,
    SLI_SYS_INIT = 3'h1,
    SLI_SYS_STOP = 3'h2,
    SLI_SYS_RUN = 3'h3,
    SLI_SYS_BADCFG = 3'h4
  } sli_sys_t;

  typedef enum logic [1:0] {
    SLI_CFG_BUSY = 2'h0,
    SLI_CFG_STORE = 2'h1,
    SLI_CFG_LOADED = 2'h2
  } sli_cfg_t;

  // lamp drive: one bit per colour
  typedef struct packed {
    logic red;
    logic green;
  } sli_ms_lamp_t;

  // core status bundle
  typedef struct packed {
    sli_sys_t sys;
    sli_cfg_t cfg;
    logic err_local;
    logic err_remote;
    logic supply_ok;
  } sli_core_t;

endpackage

/* verilog/sli_blink_gen.sv */
`timescale 1ns/1ps
// ============================================================
// free running 1 hz and 2 hz square waves
// ============================================================
module sli_blink_gen #(
  parameter int unsigned SLOW_HALF = sli_pkg::SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF = sli_pkg::FAST_HALF_CYC
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // square waves
  output logic o_slow,
  output logic o_fast
);
  import sli_pkg::*;

  logic [31:0] slow_cnt_reg;
  logic [31:0] fast_cnt_reg;

  // slow phase: toggles every half period
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      slow_cnt_reg <= 32'h0;
      o_slow <= 1'b0;
    end
    else if (slow_cnt_reg == 32'(SLOW_HALF - 1))
    begin
      slow_cnt_reg <= 32'h0;
      o_slow <= ~o_slow;
    end
    else
    begin
      slow_cnt_reg <= slow_cnt_reg + 32'h1;
    end
  end

  // fast phase: independent counter, same scheme
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      fast_cnt_reg <= 32'h0;
      o_fast <= 1'b0;
    end
    else if (fast_cnt_reg == 32'(FAST_HALF - 1))
    begin
      fast_cnt_reg <= 32'h0;
      o_fast <= ~o_fast;
    end
    else
    begin
      fast_cnt_reg <= fast_cnt_reg + 32'h1;
    end
  end

endmodule

/* verilog/sli_status_lamp.sv */
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module sli_status_lamp #(
  parameter int unsigned SLOW_HALF = sli_pkg::SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF = sli_pkg::FAST_HALF_CYC,
  parameter int unsigned N_OUT = 16,
  parameter logic [23:0] FW_VER = sli_pkg::FWVER_RST
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // state from the controller core (asynchronous to us)
  input wire sli_pkg::sli_core_t i_core,
  input wire logic [N_OUT-1:0] i_app_out,
  // lamps and system outputs
  output sli_pkg::sli_ms_lamp_t o_module_status_lamp,
  output logic o_config_verify_lamp,
  output logic [N_OUT-1:0] o_sys_out,
  output logic o_app_run,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import sli_pkg::*;

  // ==========================================================
  // input synchronisers
  // ==========================================================
  sli_core_t core_s1_reg;
  sli_core_t core_s2_reg;
  logic [N_OUT-1:0] out_s1_reg;
  logic [N_OUT-1:0] out_s2_reg;

  // two stages; only stage two feeds any logic
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      core_s1_reg <= '0;
      core_s2_reg <= '0;
      out_s1_reg <= '0;
      out_s2_reg <= '0;
    end
    else
    begin
      core_s1_reg <= i_core;
      core_s2_reg <= core_s1_reg;
      out_s1_reg <= i_app_out;
      out_s2_reg <= out_s1_reg;
    end
  end

  // ==========================================================
  // blink sources
  // ==========================================================
  logic blink_slow;
  logic blink_fast;

  sli_blink_gen #(
    .SLOW_HALF(SLOW_HALF),
    .FAST_HALF(FAST_HALF)
  ) u_blink (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .o_slow(blink_slow),
    .o_fast(blink_fast)
  );

  // ==========================================================
  // registers
  // ==========================================================
  logic [31:0] ctrl_reg;
  logic [23:0] fwver_reg;
  logic upl_err_reg;
  logic upl_ok_reg;
  logic crit_latch_reg;

  // critical error latch: held until software clears it; a new error
  // in the clearing cycle wins so nothing is lost
  logic crit_now;
  logic err_clr_wr;
  assign crit_now = core_s2_reg.err_local | core_s2_reg.err_remote;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      crit_latch_reg <= 1'b0;
    else if (crit_now)
      crit_latch_reg <= 1'b1;
    else if (err_clr_wr)
      crit_latch_reg <= 1'b0;
  end

  // ==========================================================
  // output shutoff
  // ==========================================================
  // registered so the off state cannot glitch through; costs a cycle
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      o_sys_out <= '0;
      o_app_run <= 1'b0;
    end
    else if (crit_now | crit_latch_reg)
    begin
      o_sys_out <= '0;
      o_app_run <= 1'b0;
    end
    else
    begin
      o_app_run <= (core_s2_reg.sys == SLI_SYS_RUN);
      o_sys_out <= (core_s2_reg.sys == SLI_SYS_RUN) ? out_s2_reg : '0;
    end
  end

  // ==========================================================
  // module status lamp pattern
  // ==========================================================
  sli_ms_lamp_t ms_next;
  logic err_loc_any;
  logic err_rem_any;
  assign err_loc_any = core_s2_reg.err_local;
  assign err_rem_any = core_s2_reg.err_remote;

  // priority: power, then errors, then bad config, then identify, then state
  always_comb
  begin
    ms_next = '0;
    if (!core_s2_reg.supply_ok)
      ms_next = '0;
    else if (err_loc_any)
      ms_next.red = blink_fast;
    else if (err_rem_any)
      ms_next.red = 1'b1;
    else if (core_s2_reg.sys == SLI_SYS_BADCFG)
      ms_next.red = blink_slow;
    else if (ctrl_reg[CTRL_IDENT_BIT])
      ms_next.green = blink_fast;
    else
    begin
      unique case (core_s2_reg.sys)
        SLI_SYS_OFF: ms_next = '0;
        SLI_SYS_INIT:
        begin
          ms_next.red = blink_slow;
          ms_next.green = ~blink_slow;
        end
        SLI_SYS_STOP: ms_next.green = blink_slow;
        SLI_SYS_RUN: ms_next.green = 1'b1;
        default: ms_next = '0;
      endcase
    end
  end

  // ==========================================================
  // configuration lamp pattern
  // ==========================================================
  logic cv_next;

  always_comb
  begin
    cv_next = 1'b0;
    if (core_s2_reg.supply_ok)
    begin
      unique case (core_s2_reg.cfg)
        SLI_CFG_BUSY: cv_next = 1'b0;
        SLI_CFG_STORE: cv_next = blink_fast;
        SLI_CFG_LOADED:
          cv_next = ctrl_reg[CTRL_VERIFIED_BIT] ? 1'b1
            : blink_slow;
        default: cv_next = 1'b0;
      endcase
    end
  end

  // lamps from flip-flops
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      o_module_status_lamp <= '0;
      o_config_verify_lamp <= 1'b0;
    end
    else
    begin
      o_module_status_lamp <= ms_next;
      o_config_verify_lamp <= cv_next;
    end
  end

  // ==========================================================
  // axi4-lite write path
  // ==========================================================
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_go;
  logic wr_hit;

  // accept each channel once; idle while a response waits
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_hit = (aw_addr_reg == ADDR_CTRL) || (aw_addr_reg == ADDR_UPLOAD);
  assign err_clr_wr = wr_go && (aw_addr_reg == ADDR_CTRL) &&
    w_strb_reg[0] && w_data_reg[CTRL_ERRCLR_BIT];

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // control register, byte lane 0 only; clear bit is self clearing
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      ctrl_reg <= CTRL_RST;
    else if (wr_go && aw_addr_reg == ADDR_CTRL && w_strb_reg[0])
      ctrl_reg <= {30'h0, w_data_reg[CTRL_VERIFIED_BIT],
        w_data_reg[CTRL_IDENT_BIT]};
  end

  // firmware version: fixed at reset, read only
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      fwver_reg <= FW_VER;
  end

  // upload check: newer package needs firmware V2.00.0 or later
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      upl_err_reg <= 1'b0;
      upl_ok_reg <= 1'b0;
    end
    else if (wr_go && aw_addr_reg == ADDR_UPLOAD && w_strb_reg[0] &&
      w_data_reg[UPL_GO_BIT])
    begin
      upl_err_reg <= w_data_reg[UPL_PKG2_BIT] &&
        (fwver_reg < FW_PKG2_MIN);
      upl_ok_reg <= !(w_data_reg[UPL_PKG2_BIT] &&
        (fwver_reg < FW_PKG2_MIN));
    end
  end

  // ==========================================================
  // axi4-lite read path
  // ==========================================================
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_CTRL: s_axi_rdata <= ctrl_reg;
        ADDR_STATUS: s_axi_rdata <= {21'h0, o_config_verify_lamp,
          o_module_status_lamp, core_s2_reg.cfg, core_s2_reg.sys,
          crit_latch_reg, o_app_run, core_s2_reg.supply_ok};
        ADDR_FWVER: s_axi_rdata <= {8'h00, fwver_reg};
        ADDR_UPLOAD: s_axi_rdata <= {30'h0, upl_ok_reg, upl_err_reg};
        default:
        begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule

/* bench/sli_status_lamp_props.sv */
`timescale 1ns/1ps
// ==========================================================
// port-level properties of the status lamp block
// ==========================================================
module sli_status_lamp_props
  import sli_pkg::*;
#(
  parameter int unsigned FAST_HALF = 10,
  parameter int unsigned N_OUT = 16
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // watched ports
  input wire sli_pkg::sli_core_t i_core,
  input wire logic [N_OUT-1:0] i_app_out,
  input wire sli_pkg::sli_ms_lamp_t o_module_status_lamp,
  input wire logic o_config_verify_lamp,
  input wire logic [N_OUT-1:0] o_sys_out,
  input wire logic o_app_run
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_sys_rst);
  logic [5:0] st_cnt;
  // storing run length, so the blink is judged only once settled
  always_ff @(posedge i_clk_sys)
    if (i_sys_rst || i_core.cfg != SLI_CFG_STORE)
      st_cnt <= 6'h00;
    else if (st_cnt != 6'h3F)
      st_cnt <= st_cnt + 6'h01;
  // core conditions held past the sync and lamp flops
  sequence s_nopwr;
    (!i_core.supply_ok)[*4];
  endsequence
  sequence s_local;
    (i_core.supply_ok && i_core.err_local)[*4];
  endsequence
  sequence s_remote;
    (i_core.supply_ok && i_core.err_remote && !i_core.err_local)[*4];
  endsequence
  sequence s_badcfg;
    (i_core.supply_ok && !i_core.err_local && !i_core.err_remote &&
      i_core.sys == SLI_SYS_BADCFG)[*4];
  endsequence
  sequence s_err;
    (i_core.err_local || i_core.err_remote)[*4];
  endsequence
  a_dark_nopower: assert property (s_nopwr |->
    o_module_status_lamp == 2'h0) else $error("lamp lit without supply");
  a_local_red: assert property (s_local |->
    !o_module_status_lamp.green) else $error("green on local error");
  a_remote_red: assert property (s_remote |->
    o_module_status_lamp == 2'h2) else $error("remote error not red");
  a_badcfg_red: assert property (s_badcfg |->
    !o_module_status_lamp.green) else $error("green on bad config");
  a_err_off: assert property (s_err |->
    o_sys_out == '0 && !o_app_run) else $error("outputs on at error");
  a_run_follow: assert property (o_app_run |->
    o_sys_out == $past(i_app_out, 3)) else $error("outputs not passed");
  a_busy_dark: assert property (
    (i_core.cfg == SLI_CFG_BUSY)[*4] |-> !o_config_verify_lamp)
    else $error("config lamp lit while busy");
  a_fast_half: assert property (st_cnt > 6'h10 &&
    $fell(o_config_verify_lamp) |-> $past(o_config_verify_lamp, FAST_HALF)
    && !$past(o_config_verify_lamp, FAST_HALF + 1))
    else $error("store blink half period wrong");
endmodule

/* bench/sli_lamp_eye.sv */
`timescale 1ns/1ps
// ==========================================================
// operator eye: counts lit cycles and changes of each colour
// ==========================================================
module sli_lamp_eye
  import sli_pkg::*;
(
  // clock and window restart
  input wire logic i_clk_sys,
  input wire logic i_clr,
  // lamps
  input wire sli_pkg::sli_ms_lamp_t i_ms,
  input wire logic i_cv,
  // {red on,chg, green on,chg, yellow on,chg}
  output logic [41:0] o_seen
);
  logic [2:0] now;
  logic [2:0] prev;
  logic [6:0] on_c [3];
  logic [6:0] ch_c [3];
  assign now = {i_ms.red, i_ms.green, i_cv};
  assign o_seen = {on_c[2], ch_c[2], on_c[1], ch_c[1], on_c[0], ch_c[0]};
  // tally per colour; a window of 80 cycles hides the blink phase
  always_ff @(posedge i_clk_sys)
  begin
    prev <= now;
    for (int i = 0; i < 3; i++)
    begin
      on_c[i] <= i_clr ? 7'h00 : on_c[i] + 7'(now[i]);
      ch_c[i] <= i_clr ? 7'h00 : ch_c[i] + 7'(now[i] != prev[i]);
    end
  end
endmodule

/* bench/tb.sv */
`timescale 1ns/1ps
// ==========================================================
// bench top
// ==========================================================
module tb;
  import sli_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_sys_rst = 1'b1;
  sli_core_t core = '0;
  logic [15:0] app = '0;
  logic [15:0] sys_out;
  sli_ms_lamp_t ms;
  logic cv, app_run, awr, wr, arr, bv, rv;
  logic eclr = 1'b0;
  logic [7:0] awaddr = '0;
  logic [7:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic arv = 1'b0;
  logic [1:0] bresp, rresp;
  logic [41:0] seen;
  logic [31:0] seed = 32'h6B5AB056;
  int errors = 0;
  int compares = 0;
  bit id, ver;
  // clock
  always #12.5 i_clk_sys = ~i_clk_sys;
  // short blink halves keep the run brief; older firmware hits the gate
  sli_status_lamp #(.SLOW_HALF(20), .FAST_HALF(10), .FW_VER(24'h011100))
    u_sli_status_lamp (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_core(core),
    .i_app_out(app), .o_module_status_lamp(ms), .o_config_verify_lamp(cv),
    .o_sys_out(sys_out), .o_app_run(app_run), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(1'b1));
  sli_lamp_eye u_sli_lamp_eye (.i_clk_sys(i_clk_sys), .i_clr(eclr),
    .i_ms(ms), .i_cv(cv), .o_seen(seen));
  // ========================================================
  // helpers
  // ========================================================
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // lit cycles and changes over 80 cycles: dark, steady, slow, fast
  function automatic logic [13:0] pat(input int k);
    return k == 1 ? 14'h2800 : k == 2 ? 14'h1404 : k == 3 ? 14'h1408 : 14'h0;
  endfunction
  function automatic logic [41:0] model(input sli_core_t c);
    int r, g, y;
    r = 0;
    g = 0;
    if (!c.supply_ok) r = 0;
    else if (c.err_local) r = 3;
    else if (c.err_remote) r = 1;
    else if (c.sys == SLI_SYS_BADCFG) r = 2;
    else if (id) g = 3;
    else if (c.sys == SLI_SYS_INIT)
    begin
      r = 2;
      g = 2;
    end
    else if (c.sys == SLI_SYS_STOP) g = 2;
    else if (c.sys == SLI_SYS_RUN) g = 1;
    y = c.cfg == SLI_CFG_STORE ? 3 : c.cfg == SLI_CFG_LOADED ? 2 - ver : 0;
    return {pat(r), pat(g), pat(y)};
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 60)
    begin
      errors++;
      conclude();
    end
  endtask
  // bus cycles: entered just after a rising edge
  task automatic wr32(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do
    begin
      @(posedge i_clk_sys);
      n++;
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv && n < 60);
    tmo(n);
    r = bresp;
  endtask
  task automatic rd32(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arv <= 1'b1;
    do
    begin
      @(posedge i_clk_sys);
      n++;
      if (arr) arv <= 1'b0;
    end while (!rv && n < 60);
    tmo(n);
    d = rdata;
    r = rresp;
  endtask
  task automatic look();
    repeat (6) @(posedge i_clk_sys);
    eclr <= 1'b1;
    @(posedge i_clk_sys);
    eclr <= 1'b0;
    repeat (81) @(posedge i_clk_sys);
    chk(seen, model(core));
  endtask
  // ========================================================
  // main sequence
  // ========================================================
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (4) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    @(posedge i_clk_sys);
    rd32(ADDR_FWVER, d, r);
    chk({d, r}, {32'h00011100, RESP_OKAY});
    wr32(ADDR_FWVER, 32'h0, r);
    chk(r, RESP_SLVERR);
    rd32(8'h40, d, r);
    chk({d, r}, {32'h0, RESP_SLVERR});
    // older firmware: newer package refused, older package taken
    wr32(ADDR_UPLOAD, 32'h3, r);
    rd32(ADDR_UPLOAD, d, r);
    chk({d, r}, {32'h1, RESP_OKAY});
    wr32(ADDR_UPLOAD, 32'h1, r);
    rd32(ADDR_UPLOAD, d, r);
    chk({d, r}, {32'h2, RESP_OKAY});
    core <= '{SLI_SYS_RUN, SLI_CFG_BUSY, 1'b1, 1'b0, 1'b0};
    look();
    // every state and config code meets random errors and flags
    for (int k = 0; k < 16; k++)
    begin
      d = rnd();
      id = d[8];
      ver = d[9];
      wr32(ADDR_CTRL, {30'h0, ver, id}, r);
      core <= '{sli_sys_t'(3'(k % 5)), sli_cfg_t'(2'(k % 3)),
        d[4] & d[5], d[6] & d[7], 1'b1};
      look();
      look();
    end
    d = rnd();
    id = 1'b0;
    ver = 1'b0;
    core <= '{SLI_SYS_RUN, SLI_CFG_LOADED, 1'b0, 1'b0, 1'b1};
    app <= d[15:0];
    repeat (4) @(posedge i_clk_sys);
    wr32(ADDR_CTRL, 32'h4, r);
    repeat (4) @(posedge i_clk_sys);
    chk({app_run, sys_out}, {1'b1, d[15:0]});
    look();
    core.err_remote <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    chk({app_run, sys_out}, 17'h0);
    core.err_remote <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
    chk({app_run, sys_out}, 17'h0);
    rd32(ADDR_STATUS, d, r);
    chk(d[2], 1'b1);
    wr32(ADDR_CTRL, 32'h4, r);
    repeat (4) @(posedge i_clk_sys);
    chk({app_run, sys_out}, {1'b1, app});
    conclude();
  end
  // hang guard
  initial
  begin
    repeat (90000) @(posedge i_clk_sys);
    errors++;
    conclude();
  end
endmodule
bind sli_status_lamp sli_status_lamp_props #(.FAST_HALF(FAST_HALF),
  .N_OUT(N_OUT)) u_props (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
  .i_core(i_core), .i_app_out(i_app_out),
  .o_module_status_lamp(o_module_status_lamp),
  .o_config_verify_lamp(o_config_verify_lamp), .o_sys_out(o_sys_out),
  .o_app_run(o_app_run));
